// file: serial_host_model.sv
// host side two-wire controller model for the serial link
`timescale 1ns/100ps
`default_nettype none
module serial_host_model (
    input  wire logic core_clk_in,  // paces the link
    input  wire logic sda_oe_n_in,  // device pulls data when low
    input  wire logic sda_level_in, // device data level
    output var  logic scl_out,      // serial clock, host only
    output wire logic sda_line_out  // resolved data line
);
    logic host_sda; // host data drive, high releases
    // pull-up resolves the open-drain line
    assign sda_line_out = host_sda & (sda_oe_n_in | sda_level_in);
    // clock idles high between frames
    initial begin
        scl_out = 1'b1;
        host_sda = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_in);
        #2;
    endtask
    // five clocks first so a device ack is released before the rise
    task automatic start_cond;
        host_sda = 1'b1;
        tick(5);
        scl_out = 1'b1;
        tick(3);
        host_sda = 1'b0;
        tick(3);
        scl_out = 1'b0;
    endtask
    task automatic stop_cond;
        host_sda = 1'b0;
        tick(5);
        scl_out = 1'b1;
        tick(3);
        host_sda = 1'b1;
        tick(3);
    endtask
    // nine bits msb first: low 5 clocks, high 3, one 320 ns period
    task automatic xfer(input [8:0] d, output logic [8:0] q);
        for (int i = 8; i >= 0; i--) begin
            tick(2);
            host_sda = d[i];
            tick(3);
            scl_out = 1'b1;
            tick(3);
            q[i] = sda_line_out;
            scl_out = 1'b0;
        end
    endtask
endmodule // serial_host_model
`default_nettype wire

// file: serial_id_consts.vh
// constants for the module serial id and diagnostics memory target
`ifndef SERIAL_ID_CONSTS_VH
`define SERIAL_ID_CONSTS_VH

// ----------------------------------------------------------------------
// serial device address
// ----------------------------------------------------------------------
`define DIAG_DEV_ADDR   7'h51

// ----------------------------------------------------------------------
// diagnostics page map (byte offsets)
// ----------------------------------------------------------------------
`define THR_LAST        8'h37
`define CAL_LAST        8'h5F
`define RT_FIRST        8'h60
`define RT_TEMP_MSB     8'h60
`define RT_TEMP_LSB     8'h61
`define RT_VCC_MSB      8'h62
`define RT_VCC_LSB      8'h63
`define RT_BIAS_MSB     8'h64
`define RT_BIAS_LSB     8'h65
`define RT_TXPWR_MSB    8'h66
`define RT_TXPWR_LSB    8'h67
`define RT_RXPWR_MSB    8'h68
`define RT_RXPWR_LSB    8'h69
`define RT_STATUS       8'h6E
`define USER_FIRST      8'h80
`define USER_LAST       8'hF7

// ----------------------------------------------------------------------
// status byte field positions
// ----------------------------------------------------------------------
`define ST_PIN_DIS_BIT  7
`define ST_SOFT_DIS_BIT 6
`define ST_FAULT_BIT    2
`define ST_LOST_BIT     1
`define ST_READY_BIT    0

// ----------------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------------
`define SOFT_DIS_RST    1'h0
`define BIT_CNT_LAST    3'h7
`define BYTE_IDX_DEV    2'h0
`define BYTE_IDX_WORD   2'h1
`define BYTE_IDX_DATA   2'h2

`endif

// file: serial_id_diag_memory.v
// serial id and diagnostics memory target with module status pins
//
// Functional notes
// RULE1 - host alone drives the serial clock
// RULE2 - capture on clock rise, only unprotected bytes
// RULE3 - launch read data on clock fall
// RULE4 - host frames transfers with start and stop
// RULE5 - byte words, single or sequential access
// RULE6 - answer at seven-bit address 1010001
// RULE7 - bytes 0 to 55 hold thresholds
// RULE8 - 56-95 calibration, 96-119 live monitor values
// RULE9 - vendor, user-writable 128-247, vendor areas
// RULE10 - thresholds and calibration fixed at build
// RULE11 - host scales raw codes with calibration
// RULE12 - publish rx, tx power, bias, vcc, temp
// RULE13 - fault pin low normal, released on fault
// RULE14 - transmitter off when disable pin high
// RULE15 - presence line held at ground
// RULE16 - lost pin released high on lost signal
// RULE17 - soft disable write, status bits readable
// RULE18 - address advances per byte, wraps page
`timescale 1ns/100ps
`default_nettype none
`include "serial_id_consts.vh"

module serial_id_diag_memory #(
    // thresholds and calibration, byte n at bits [8n+7:8n]
    parameter [767:0] factory_image = 768'h0
) (
    input  wire        core_clk_in,       // 25 MHz core clock
    input  wire        reset_in,          // synchronous, active high
    input  wire        scl_in,            // serial clock from host
    input  wire        sda_in,            // serial data line level
    output wire        sda_out,           // level driven when enabled
    output reg         sda_oe_n_out,      // low pulls the data line
    input  wire        tx_disable_pin_in, // disable pin, pulled up
    input  wire        laser_fault_in,    // laser fault detector
    input  wire        signal_lost_in,    // receive signal detector
    input  wire [15:0] temp_code_in,      // raw temperature code
    input  wire [15:0] vcc_code_in,       // raw supply voltage code
    input  wire [15:0] bias_code_in,      // raw laser bias code
    input  wire [15:0] tx_power_code_in,  // raw tx power code
    input  wire [15:0] rx_power_code_in,  // raw rx power code
    output reg         laser_enable_out,  // high lets the laser emit
    output wire        fault_pin_out,     // level when enabled
    output reg         fault_oe_n_out,    // low pulls fault pin
    output wire        present_out,       // level when enabled
    output reg         present_oe_n_out,  // low grounds presence
    output wire        rx_signal_lost_flag_out,      // level driven
    output reg         rx_signal_lost_flag_oe_n_out  // low pulls pin
);

    // ------------------------------------------------------------------
    // state encoding
    // ------------------------------------------------------------------
    localparam [4:0] S_IDLE = 5'h01; // waiting for a start
    localparam [4:0] S_RXB  = 5'h02; // shifting a byte in
    localparam [4:0] S_ACK  = 5'h04; // driving our acknowledge
    localparam [4:0] S_TXB  = 5'h08; // shifting a byte out
    localparam [4:0] S_RACK = 5'h10; // sampling host acknowledge

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    reg  [2:0] scl_sync;      // clock pin synchroniser and delay
    reg  [2:0] sda_sync;      // data pin synchroniser and delay
    reg  [1:0] dis_sync;      // disable pin synchroniser
    reg  [1:0] fault_sync;    // fault detector synchroniser
    reg  [1:0] lost_sync;     // lost detector synchroniser
    reg  [4:0] state;         // transfer state, one-hot
    reg  [2:0] bit_cnt;       // bit position within byte
    reg  [1:0] byte_idx;      // device, word address or data
    reg  [7:0] shift;         // byte shift register
    reg  [7:0] addr;          // page byte pointer
    reg        read_mode;     // current transfer is a read
    reg        host_nack;     // host declined more data
    reg        soft_dis;      // disable set over the serial link
    reg  [7:0] user_mem [0:119]; // user-writable storage
    reg  [7:0] rd_byte;       // byte at the pointer
    reg        wr_en;         // one-cycle store strobe
    reg  [7:0] wr_data;       // byte being stored
    reg  [7:0] wr_addr;       // page offset being stored
    wire       scl_rise;      // clock rising edge seen
    wire       scl_fall;      // clock falling edge seen
    wire       start_cond;    // data falls with clock high
    wire       stop_cond;     // data rises with clock high
    wire [7:0] rx_full;       // completed incoming byte
    wire [7:0] user_idx;      // pointer relative to user area
    wire       user_hit;      // pointer inside user area

    // ------------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------------
    // two flops per outside input; the third clock and data stage only
    // delays the clean copy for edge detection
    always @(posedge core_clk_in) begin
        if (reset_in) begin
            scl_sync   <= 3'h7;
            sda_sync   <= 3'h7;
            dis_sync   <= 2'h3;
            fault_sync <= 2'h0;
            lost_sync  <= 2'h0;
        end else begin
            scl_sync   <= {scl_sync[1:0], scl_in}; // see RULE1
            sda_sync   <= {sda_sync[1:0], sda_in};
            dis_sync   <= {dis_sync[0], tx_disable_pin_in};
            fault_sync <= {fault_sync[0], laser_fault_in};
            lost_sync  <= {lost_sync[0], signal_lost_in};
        end
    end

    // ------------------------------------------------------------------
    // edge and condition detection
    // ------------------------------------------------------------------
    assign scl_rise   = scl_sync[1] & ~scl_sync[2];
    assign scl_fall   = ~scl_sync[1] & scl_sync[2];
    // framing is seen only while the clock stays high, see RULE4
    assign start_cond = scl_sync[1] & scl_sync[2] &
                        ~sda_sync[1] & sda_sync[2];
    assign stop_cond  = scl_sync[1] & scl_sync[2] &
                        sda_sync[1] & ~sda_sync[2];
    assign rx_full    = {shift[6:0], sda_sync[1]};
    assign user_idx   = addr - `USER_FIRST;
    assign user_hit   = (addr >= `USER_FIRST) && (addr <= `USER_LAST);

    // ------------------------------------------------------------------
    // read multiplexer for the diagnostics page
    // ------------------------------------------------------------------
    always @* begin
        rd_byte = 8'h00; // vendor and unused bytes read zero
        if (addr <= `CAL_LAST) begin
            // factory thresholds and calibration, see RULE7
            // addr is below 96 here, so seven bits give the offset
            // see RULE10
            rd_byte = factory_image[{addr[6:0], 3'h0} +: 8]; // see RULE8
        end else if (user_hit) begin
            rd_byte = user_mem[user_idx[6:0]]; // see RULE9
        end else begin
            // live raw converter codes, see RULE11
            case (addr)
                `RT_TEMP_MSB:  rd_byte = temp_code_in[15:8]; // see RULE12
                `RT_TEMP_LSB:  rd_byte = temp_code_in[7:0];
                `RT_VCC_MSB:   rd_byte = vcc_code_in[15:8];
                `RT_VCC_LSB:   rd_byte = vcc_code_in[7:0];
                `RT_BIAS_MSB:  rd_byte = bias_code_in[15:8];
                `RT_BIAS_LSB:  rd_byte = bias_code_in[7:0];
                `RT_TXPWR_MSB: rd_byte = tx_power_code_in[15:8];
                `RT_TXPWR_LSB: rd_byte = tx_power_code_in[7:0];
                `RT_RXPWR_MSB: rd_byte = rx_power_code_in[15:8];
                `RT_RXPWR_LSB: rd_byte = rx_power_code_in[7:0];
                `RT_STATUS: begin
                    // readable module state, see RULE17
                    rd_byte[`ST_PIN_DIS_BIT]  = dis_sync[1];
                    rd_byte[`ST_SOFT_DIS_BIT] = soft_dis;
                    rd_byte[`ST_FAULT_BIT]    = fault_sync[1];
                    rd_byte[`ST_LOST_BIT]     = lost_sync[1];
                    rd_byte[`ST_READY_BIT]    = 1'b1;
                end
                default: rd_byte = 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // serial transfer engine
    // ------------------------------------------------------------------
    always @(posedge core_clk_in) begin
        if (reset_in) begin
            state        <= S_IDLE;
            bit_cnt      <= 3'h0;
            byte_idx     <= `BYTE_IDX_DEV;
            shift        <= 8'h00;
            addr         <= 8'h00;
            read_mode    <= 1'b0;
            host_nack    <= 1'b0;
            sda_oe_n_out <= 1'b1;
            wr_en        <= 1'b0;
            wr_data      <= 8'h00;
            wr_addr      <= 8'h00;
        end else begin
            wr_en <= 1'b0;
            if (start_cond) begin
                // start or repeated start: expect device address
                state        <= S_RXB;
                bit_cnt      <= 3'h0;
                byte_idx     <= `BYTE_IDX_DEV;
                sda_oe_n_out <= 1'b1;
            end else if (stop_cond) begin
                state        <= S_IDLE;
                sda_oe_n_out <= 1'b1;
            end else begin
                case (state)
                    S_IDLE: begin
                        sda_oe_n_out <= 1'b1;
                    end
                    S_RXB: begin
                        if (scl_rise) begin
                            shift   <= rx_full; // see RULE2
                            bit_cnt <= bit_cnt + 3'h1;
                            if (bit_cnt == `BIT_CNT_LAST) begin
                                if (byte_idx == `BYTE_IDX_DEV) begin
                                    read_mode <= rx_full[0];
                                    // foreign address: stay silent
                                    if (rx_full[7:1] != `DIAG_DEV_ADDR) begin
                                        state <= S_IDLE; // see RULE6
                                    end
                                end else if (byte_idx == `BYTE_IDX_WORD) begin
                                    addr <= rx_full; // see RULE5
                                end else begin
                                    // store request, then advance
                                    wr_en   <= 1'b1;
                                    wr_data <= rx_full;
                                    wr_addr <= addr;
                                    addr    <= addr + 8'h01; // see RULE18
                                end
                                if (byte_idx != `BYTE_IDX_DATA) begin
                                    byte_idx <= byte_idx + 2'h1;
                                end
                            end
                        end else if (scl_fall && bit_cnt == 3'h0 &&
                                     byte_idx != `BYTE_IDX_DEV) begin
                            // byte complete: acknowledge it
                            state        <= S_ACK;
                            sda_oe_n_out <= 1'b0;
                        end
                    end
                    S_ACK: begin
                        if (scl_fall) begin
                            bit_cnt <= 3'h0;
                            if (read_mode) begin
                                // first read byte leaves on this fall
                                state        <= S_TXB;
                                shift        <= rd_byte;
                                sda_oe_n_out <= rd_byte[7]; // see RULE3
                                addr         <= addr + 8'h01; // see RULE18
                            end else begin
                                state        <= S_RXB;
                                sda_oe_n_out <= 1'b1;
                            end
                        end
                    end
                    S_TXB: begin
                        if (scl_fall) begin
                            if (bit_cnt == `BIT_CNT_LAST) begin
                                // free the line for host acknowledge
                                state        <= S_RACK;
                                sda_oe_n_out <= 1'b1;
                            end else begin
                                shift        <= {shift[6:0], 1'b0};
                                sda_oe_n_out <= shift[6]; // see RULE3
                                bit_cnt      <= bit_cnt + 3'h1;
                            end
                        end
                    end
                    S_RACK: begin
                        if (scl_rise) begin
                            host_nack <= sda_sync[1];
                        end else if (scl_fall) begin
                            bit_cnt <= 3'h0;
                            if (!host_nack) begin
                                // sequential read continues, see RULE5
                                state        <= S_TXB;
                                shift        <= rd_byte;
                                sda_oe_n_out <= rd_byte[7]; // see RULE3
                                addr         <= addr + 8'h01; // see RULE18
                            end else begin
                                state <= S_IDLE;
                            end
                        end
                    end
                    default: begin
                        state        <= S_IDLE;
                        sda_oe_n_out <= 1'b1;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // store port: only unprotected bytes accept data
    // ------------------------------------------------------------------
    // user storage carries no reset, as a non-volatile store would
    always @(posedge core_clk_in) begin
        if (wr_en && wr_addr >= `USER_FIRST && wr_addr <= `USER_LAST) begin
            // user area starts at 128: low seven bits are the index
            user_mem[wr_addr[6:0]] <= wr_data; // see RULE2 see RULE9
        end
    end

    // soft disable bit of the status byte
    always @(posedge core_clk_in) begin
        if (reset_in) begin
            soft_dis <= `SOFT_DIS_RST;
        end else if (wr_en && wr_addr == `RT_STATUS) begin
            soft_dis <= wr_data[`ST_SOFT_DIS_BIT]; // see RULE17
        end
    end

    // ------------------------------------------------------------------
    // module status pins
    // ------------------------------------------------------------------
    // open-drain pins only ever pull low
    assign sda_out                 = 1'b0;
    assign fault_pin_out           = 1'b0;
    assign present_out             = 1'b0;
    assign rx_signal_lost_flag_out = 1'b0;

    always @(posedge core_clk_in) begin
        if (reset_in) begin
            laser_enable_out             <= 1'b0;
            fault_oe_n_out               <= 1'b0;
            present_oe_n_out             <= 1'b0;
            rx_signal_lost_flag_oe_n_out <= 1'b0;
        end else begin
            // pin or serial disable shuts the laser
            laser_enable_out <= ~(dis_sync[1] | soft_dis); // see RULE14
            // released pin floats high on a fault
            fault_oe_n_out   <= fault_sync[1]; // see RULE13
            present_oe_n_out <= 1'b0; // see RULE15
            rx_signal_lost_flag_oe_n_out <= lost_sync[1]; // see RULE16
        end
    end

endmodule // serial_id_diag_memory
`default_nettype wire

// file: serial_id_diag_memory_chk.sv
// pin-level assertion checker for the serial id memory target
`timescale 1ns/100ps
`default_nettype none
module serial_id_diag_memory_chk (
    input wire logic core_clk_in,                 // core clock
    input wire logic reset_in,                    // sync reset
    input wire logic scl_in,                      // serial clock
    input wire logic tx_disable_pin_in,           // disable pin
    input wire logic laser_fault_in,              // fault detector
    input wire logic signal_lost_in,              // lost detector
    input wire logic sda_out,                     // data level
    input wire logic sda_oe_n_out,                // data enable
    input wire logic laser_enable_out,            // laser on
    input wire logic fault_pin_out,               // fault level
    input wire logic fault_oe_n_out,              // fault enable
    input wire logic present_out,                 // presence level
    input wire logic present_oe_n_out,            // presence enable
    input wire logic rx_signal_lost_flag_out,     // lost level
    input wire logic rx_signal_lost_flag_oe_n_out // lost enable
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (reset_in);
    // ------------------------------------------------------------
    // status pins
    // ------------------------------------------------------------
    a_present_ground: assert property (
        !present_oe_n_out && !present_out) else $error("presence not low");
    a_open_drain_low: assert property (
        !sda_out && !fault_pin_out && !rx_signal_lost_flag_out)
        else $error("open drain level not low");
    a_fault_raise: assert property (
        $rose(laser_fault_in) |-> ##[1:4] fault_oe_n_out)
        else $error("fault pin not released");
    a_fault_clear: assert property (
        $fell(laser_fault_in) |-> ##[1:4] !fault_oe_n_out)
        else $error("fault pin not pulled low");
    a_lost_raise: assert property (
        signal_lost_in [*4] |-> rx_signal_lost_flag_oe_n_out)
        else $error("lost pin not released");
    a_lost_clear: assert property (
        !signal_lost_in [*4] |-> !rx_signal_lost_flag_oe_n_out)
        else $error("lost pin not pulled low");
    a_pin_disable: assert property (
        tx_disable_pin_in [*4] |-> !laser_enable_out)
        else $error("laser on with disable pin high");
    // ------------------------------------------------------------
    // serial data timing: change only while the clock is low
    // ------------------------------------------------------------
    a_drive_clk_low: assert property (
        $fell(sda_oe_n_out) |-> !scl_in) else $error("data driven in high");
    a_hold_clk_high: assert property (
        scl_in && $past(scl_in) |-> $stable(sda_oe_n_out))
        else $error("data moved while clock high");
endmodule // serial_id_diag_memory_chk
bind serial_id_diag_memory serial_id_diag_memory_chk u_chk (
    .core_clk_in(core_clk_in), .reset_in(reset_in), .scl_in(scl_in),
    .tx_disable_pin_in(tx_disable_pin_in),
    .laser_fault_in(laser_fault_in), .signal_lost_in(signal_lost_in),
    .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out),
    .laser_enable_out(laser_enable_out), .fault_pin_out(fault_pin_out),
    .fault_oe_n_out(fault_oe_n_out), .present_out(present_out),
    .present_oe_n_out(present_oe_n_out),
    .rx_signal_lost_flag_out(rx_signal_lost_flag_out),
    .rx_signal_lost_flag_oe_n_out(rx_signal_lost_flag_oe_n_out));
`default_nettype wire

// file: serial_id_diag_memory_tb_top.sv
// testbench for the serial id and diagnostics memory target
`timescale 1ns/100ps
`default_nettype none
`include "serial_id_consts.vh"
module serial_id_diag_memory_tb_top;
    localparam [767:0] image = {48{16'h5AC3}}; // even C3, odd 5A
    logic        core_clk_in; // 25 MHz clock
    logic        reset_in;    // sync reset
    logic        tx_dis_host; // high leaves the pulled-up pin open
    logic        fault_in;    // fault detector
    logic        lost_in;     // lost detector
    logic [79:0] codes;       // raw temp vcc bias tx rx
    logic [7:0]  rbuf [0:9];  // bytes read back
    int          n_mismatch;
    int          compares;
    wire         scl, sda_line, sda_out, sda_oe_n, laser_en;
    wire         f_pin, f_oe_n, p_pin, p_oe_n, l_pin, l_oe_n;
    wire         fault_line = f_oe_n | f_pin; // pulled up on board
    wire         lost_line = l_oe_n | l_pin;
    wire         pres_line = p_oe_n | p_pin;
    serial_id_diag_memory #(.factory_image(image)) DUT (
        .core_clk_in(core_clk_in), .reset_in(reset_in), .scl_in(scl),
        .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n_out(sda_oe_n),
        .tx_disable_pin_in(tx_dis_host), .laser_fault_in(fault_in),
        .signal_lost_in(lost_in), .temp_code_in(codes[79:64]),
        .vcc_code_in(codes[63:48]), .bias_code_in(codes[47:32]),
        .tx_power_code_in(codes[31:16]), .rx_power_code_in(codes[15:0]),
        .laser_enable_out(laser_en), .fault_pin_out(f_pin),
        .fault_oe_n_out(f_oe_n), .present_out(p_pin),
        .present_oe_n_out(p_oe_n), .rx_signal_lost_flag_out(l_pin),
        .rx_signal_lost_flag_oe_n_out(l_oe_n));
    serial_host_model u_host (.core_clk_in(core_clk_in),
        .sda_oe_n_in(sda_oe_n), .sda_level_in(sda_out),
        .scl_out(scl), .sda_line_out(sda_line));
    initial begin
        core_clk_in = 1'b0;
        forever #20 core_clk_in = ~core_clk_in;
    end
    task automatic step(input int n);
        repeat (n) @(posedge core_clk_in);
        #2;
    endtask
    task automatic chk(input string what, input [7:0] exp, input [7:0] got);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic send(input [7:0] b, input ack_exp);
        logic [8:0] q;
        u_host.xfer({b, 1'b1}, q);
        chk("ack", {7'h0, !ack_exp}, {7'h0, q[0]});
    endtask
    task automatic wr(input [7:0] ptr, input [15:0] d, input int n);
        u_host.start_cond();
        send({`DIAG_DEV_ADDR, 1'b0}, 1'b1);
        send(ptr, 1'b1);
        for (int i = 0; i < n; i++)
            send(d[15-8*i -: 8], 1'b1);
        u_host.stop_cond();
    endtask
    // random read: pointer write, stop, fresh start, nack on the last byte
    task automatic rd(input [7:0] ptr, input int n);
        logic [8:0] q;
        wr(ptr, 16'h0, 0);
        u_host.start_cond();
        send({`DIAG_DEV_ADDR, 1'b1}, 1'b1);
        for (int i = 0; i < n; i++) begin
            u_host.xfer({8'hFF, i == n - 1}, q);
            rbuf[i] = q[8:1];
        end
        u_host.stop_cond();
    endtask
    task automatic t_pins;
        fault_in = 1'b1;
        lost_in = 1'b1;
        tx_dis_host = 1'b1;
        step(6);
        chk("fault up", 8'h1, {7'h0, fault_line});
        chk("lost up", 8'h1, {7'h0, lost_line});
        chk("laser off", 8'h0, {7'h0, laser_en});
        fault_in = 1'b0;
        lost_in = 1'b0;
        tx_dis_host = 1'b0;
        step(6);
        chk("fault low", 8'h0, {7'h0, fault_line});
        chk("lost low", 8'h0, {7'h0, lost_line});
        chk("laser on", 8'h1, {7'h0, laser_en});
        chk("present", 8'h0, {7'h0, pres_line});
        $display("test pins done");
    endtask
    task automatic t_addr;
        logic [23:0] bad = 24'hA0A622;
        for (int i = 0; i < 3; i++) begin
            u_host.start_cond();
            send(bad[23-8*i -: 8], 1'b0);
            u_host.stop_cond();
        end
        $display("test address done");
    endtask
    task automatic t_map;
        wr(8'h37, 16'hEEEE, 2);
        rd(8'h36, 3);
        chk("thr 54", 8'hC3, rbuf[0]);
        chk("thr 55", 8'h5A, rbuf[1]);
        chk("cal 56", 8'hC3, rbuf[2]);
        rd(`CAL_LAST, 1);
        chk("cal 95", 8'h5A, rbuf[0]);
        $display("test map done");
    endtask
    task automatic t_user;
        wr(8'h7F, 16'h1122, 2);
        wr(`USER_LAST, 16'h9669, 2);
        rd(8'h7F, 2);
        chk("vendor 127", 8'h00, rbuf[0]);
        chk("user 128", 8'h22, rbuf[1]);
        rd(`USER_LAST, 2);
        chk("user 247", 8'h96, rbuf[0]);
        chk("vendor 248", 8'h00, rbuf[1]);
        rd(8'hFF, 2);
        chk("wrap 0", 8'hC3, rbuf[1]);
        $display("test user done");
    endtask
    task automatic t_mon;
        codes = 80'h1234_5678_9ABC_DEF0_0F1E;
        step(4);
        rd(`RT_FIRST, 10);
        for (int i = 0; i < 10; i++)
            chk("monitor", codes[79-8*i -: 8], rbuf[i]);
        $display("test monitor done");
    endtask
    task automatic t_status;
        fault_in = 1'b1;
        lost_in = 1'b1;
        wr(`RT_STATUS, 16'h4000, 1);
        step(4);
        chk("soft off", 8'h0, {7'h0, laser_en});
        rd(`RT_STATUS, 1);
        chk("status", 8'h47, rbuf[0] & 8'hC7);
        wr(`RT_STATUS, 16'h0000, 1);
        step(4);
        chk("soft on", 8'h1, {7'h0, laser_en});
        $display("test status done");
    endtask
    task automatic finish_test;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // watchdog cuts a hang short
    initial begin
        repeat (100000) @(posedge core_clk_in);
        n_mismatch++;
        finish_test();
    end
    initial begin
        reset_in = 1'b1;
        tx_dis_host = 1'b0;
        fault_in = 1'b0;
        lost_in = 1'b0;
        codes = 80'h0;
        n_mismatch = 0;
        compares = 0;
        step(12);
        reset_in = 1'b0;
        step(4);
        t_pins();
        t_addr();
        t_map();
        t_user();
        t_mon();
        t_status();
        finish_test();
    end
endmodule // serial_id_diag_memory_tb_top
`default_nettype wire
